// File: hdl/ppr_params.svh
// constants of the peripheral pin router
`ifndef PPR_PARAMS_SVH
`define PPR_PARAMS_SVH

// ****************************************************************
// bus geometry
// ****************************************************************
`define PPR_AXI_AW          8
`define PPR_AXI_DW          32
`define PPR_IDX_W           6
`define PPR_RESP_OKAY       2'h0
`define PPR_RESP_SLVERR     2'h2

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PPR_IDX_SERIAL      6'h02
`define PPR_IDX_SPI         6'h03
`define PPR_IDX_TIMER_A     6'h04
`define PPR_IDX_TIMER_B     6'h05

// ****************************************************************
// reset values
// ****************************************************************
`define PPR_RST_SERIAL      4'h0
`define PPR_RST_SPI         2'h0
`define PPR_RST_TIMER_A     6'h00
`define PPR_RST_TIMER_B     2'h0

// ****************************************************************
// field positions
// ****************************************************************
`define PPR_SER0_LSB        0
`define PPR_SER1_LSB        2
`define PPR_SPI_LSB         0
`define PPR_TMRB0_BIT       0
`define PPR_TMRB1_BIT       1

// ****************************************************************
// pin numbering: port base plus bit
// ****************************************************************
`define PPR_PINS            24
`define PPR_PORT_A          5'h00
`define PPR_PORT_B          5'h08
`define PPR_PORT_C          5'h10

`endif

// File: hdl/ppr_pkg.sv
// types shared by the peripheral pin router
package ppr_pkg;

   // routing field encodings of the serial and spi groups
   typedef enum logic [1:0] {
      PPR_ROUTE_DEFAULT  = 2'h0,
      PPR_ROUTE_ALT      = 2'h1,
      PPR_ROUTE_RESERVED = 2'h2,
      PPR_ROUTE_NONE     = 2'h3
   } ppr_route_e;

   typedef logic [4:0] ppr_pin_t;

endpackage : ppr_pkg

// File: hdl/ppr_reg_if.sv
// register access carrier between bus slave and register file
`timescale 1ns/1ps
`include "ppr_params.svh"

interface ppr_reg_if;
   logic                   wr_en;
   logic [`PPR_IDX_W-1:0]  wr_idx;
   logic [7:0]             wr_data;
   logic                   wr_lane0;
   logic                   wr_err;
   logic [`PPR_IDX_W-1:0]  rd_idx;
   logic [7:0]             rd_data;
   logic                   rd_err;

   modport bus (output wr_en, output wr_idx, output wr_data, output wr_lane0,
                input wr_err, output rd_idx, input rd_data, input rd_err);
   modport regs (input wr_en, input wr_idx, input wr_data, input wr_lane0,
                 output wr_err, input rd_idx, output rd_data, output rd_err);
endinterface : ppr_reg_if

// File: hdl/ppr_pin_cell.sv
// one pin: peripheral override of general-purpose drive, registered
`timescale 1ns/1ps

module ppr_pin_cell (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   input  wire logic gpio_out,
   input  wire logic gpio_oe,
   input  wire logic own,
   input  wire logic per_out,
   input  wire logic per_oe,
   output logic      pin_out,
   output logic      pin_oe
);

   // owning peripheral drives, otherwise general-purpose control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else if (ce) begin
         pin_out <= own ? per_out : gpio_out;
         pin_oe  <= own ? per_oe : gpio_oe;
      end
   end

endmodule : ppr_pin_cell

// File: hdl/ppr_axil_slave.sv
// axi4-lite slave front end for the router registers
`timescale 1ns/1ps
`include "ppr_params.svh"

module ppr_axil_slave (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   ce,
   input  wire logic [`PPR_AXI_AW-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [`PPR_AXI_DW-1:0] wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [`PPR_AXI_AW-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [`PPR_AXI_DW-1:0]      rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   ppr_reg_if.bus                      rif
);

   logic                   aw_got;
   logic                   w_got;
   logic                   ar_got;
   logic [`PPR_IDX_W-1:0]  aw_idx;
   logic [`PPR_IDX_W-1:0]  ar_idx;
   logic [7:0]             w_byte;
   logic                   w_lane0;

   // ****************************************************************
   // write path
   // ****************************************************************
   assign rif.wr_en    = aw_got && w_got && !bvalid;
   assign rif.wr_idx   = aw_idx;
   assign rif.wr_data  = w_byte;
   assign rif.wr_lane0 = w_lane0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_got  <= 1'b0;
         aw_idx  <= '0;
      end else if (ce) begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_got  <= 1'b1;
            aw_idx  <= awaddr[`PPR_AXI_AW-1:2];
         end else if (rif.wr_en) begin
            aw_got  <= 1'b0;
         end else if (!aw_got && !bvalid) begin
            awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready  <= 1'b0;
         w_got   <= 1'b0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (ce) begin
         if (wvalid && wready) begin
            wready  <= 1'b0;
            w_got   <= 1'b1;
            w_byte  <= wdata[7:0];
            w_lane0 <= wstrb[0];
         end else if (rif.wr_en) begin
            w_got   <= 1'b0;
         end else if (!w_got && !bvalid) begin
            wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `PPR_RESP_OKAY;
      end else if (ce) begin
         if (rif.wr_en) begin
            bvalid <= 1'b1;
            bresp  <= rif.wr_err ? `PPR_RESP_SLVERR : `PPR_RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   assign rif.rd_idx = ar_idx;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         ar_got  <= 1'b0;
         ar_idx  <= '0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= `PPR_RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            ar_got  <= 1'b1;
            ar_idx  <= araddr[`PPR_AXI_AW-1:2];
         end else if (ar_got) begin
            ar_got  <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h000000, rif.rd_data};
            rresp   <= rif.rd_err ? `PPR_RESP_SLVERR : `PPR_RESP_OKAY;
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
         end else if (!rvalid) begin
            arready <= 1'b1;
         end
      end
   end

endmodule : ppr_axil_slave

// File: hdl/ppr_pin_router.sv
// peripheral pin router: routing registers and pin override
// Function
// - serial port one field bits 3:2: 0 on PA1-PA4, 1 on PC2,PC1,PC0,PC3
// - serial port zero field bits 1:0: 0 on PB2,PB3,PB1,PB0, 1 on PA1-PA4
// - spi field: 0 on PA1-PA4, 1 on PC2,PC1,PC0,PC3
// - value 3 in a serial or spi field connects that peripheral to no pin
// - six timer bits each move one waveform output to its alternate pin
// - single timer one output on PA3 when clear, PC4 when set
// - single timer zero output on PA5 when clear, PC0 when set
// - enabled routed peripheral overrides its pins; other pins stay general-purpose
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ppr_params.svh"

module ppr_pin_router (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   ce,
   input  wire logic [`PPR_AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [`PPR_AXI_DW-1:0] s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [`PPR_AXI_AW-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [`PPR_AXI_DW-1:0]      s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic [`PPR_PINS-1:0]   gpio_out,
   input  wire logic [`PPR_PINS-1:0]   gpio_oe,
   input  wire logic [`PPR_PINS-1:0]   pin_in,
   output logic [`PPR_PINS-1:0]        pin_out,
   output logic [`PPR_PINS-1:0]        pin_oe,
   input  wire logic                   serial_port_zero_en,
   input  wire logic [3:0]             serial_port_zero_out,
   input  wire logic [3:0]             serial_port_zero_oe,
   output logic [3:0]                  serial_port_zero_in,
   input  wire logic                   serial_port_one_en,
   input  wire logic [3:0]             serial_port_one_out,
   input  wire logic [3:0]             serial_port_one_oe,
   output logic [3:0]                  serial_port_one_in,
   input  wire logic                   spi_port_zero_en,
   input  wire logic [3:0]             spi_port_zero_out,
   input  wire logic [3:0]             spi_port_zero_oe,
   output logic [3:0]                  spi_port_zero_in,
   input  wire logic [5:0]             six_output_timer_en,
   input  wire logic [5:0]             six_output_timer_wo,
   input  wire logic                   single_output_timer_zero_en,
   input  wire logic                   single_output_timer_zero_wo,
   input  wire logic                   single_output_timer_one_en,
   input  wire logic                   single_output_timer_one_wo
);

   // ****************************************************************
   // pin tables, line order: data out, data in, clock, select/direction
   // ****************************************************************
   localparam ppr_pkg::ppr_pin_t SER0_DEF [4] = '{
      `PPR_PORT_B + 5'd2, `PPR_PORT_B + 5'd3, `PPR_PORT_B + 5'd1, `PPR_PORT_B + 5'd0};
   localparam ppr_pkg::ppr_pin_t PA_1TO4  [4] = '{
      `PPR_PORT_A + 5'd1, `PPR_PORT_A + 5'd2, `PPR_PORT_A + 5'd3, `PPR_PORT_A + 5'd4};
   localparam ppr_pkg::ppr_pin_t PC_ALT   [4] = '{
      `PPR_PORT_C + 5'd2, `PPR_PORT_C + 5'd1, `PPR_PORT_C + 5'd0, `PPR_PORT_C + 5'd3};
   localparam ppr_pkg::ppr_pin_t TMRA_DEF [6] = '{
      `PPR_PORT_B + 5'd0, `PPR_PORT_B + 5'd1, `PPR_PORT_B + 5'd2,
      `PPR_PORT_A + 5'd3, `PPR_PORT_A + 5'd4, `PPR_PORT_A + 5'd5};
   localparam ppr_pkg::ppr_pin_t TMRA_ALT [6] = '{
      `PPR_PORT_B + 5'd3, `PPR_PORT_B + 5'd4, `PPR_PORT_B + 5'd5,
      `PPR_PORT_C + 5'd3, `PPR_PORT_C + 5'd4, `PPR_PORT_C + 5'd5};
   localparam ppr_pkg::ppr_pin_t TMRB0_DEF = `PPR_PORT_A + 5'd5;
   localparam ppr_pkg::ppr_pin_t TMRB0_ALT = `PPR_PORT_C + 5'd0;
   localparam ppr_pkg::ppr_pin_t TMRB1_DEF = `PPR_PORT_A + 5'd3;
   localparam ppr_pkg::ppr_pin_t TMRB1_ALT = `PPR_PORT_C + 5'd4;

   // ****************************************************************
   // declarations
   // ****************************************************************
   ppr_reg_if rif ();

   logic [3:0]                serial_route_select;
   logic [1:0]                spi_route_select;
   logic [5:0]                timer_a_route_select;
   logic [1:0]                timer_b_route_select;
   ppr_pkg::ppr_route_e       grp_route [3];
   ppr_pkg::ppr_pin_t         grp_def   [3][4];
   ppr_pkg::ppr_pin_t         grp_alt   [3][4];
   logic [2:0]                grp_en;
   logic [3:0]                grp_out   [3];
   logic [3:0]                grp_oe    [3];
   logic [3:0]                next_grp_in [3];
   logic [`PPR_PINS-1:0]      own;
   logic [`PPR_PINS-1:0]      per_out;
   logic [`PPR_PINS-1:0]      per_oe;

   // ****************************************************************
   // bus slave
   // ****************************************************************
   ppr_axil_slave u_slave (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .rif     (rif.bus)
   );

   // ****************************************************************
   // routing registers
   // ****************************************************************
   // zero on reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_route_select  <= `PPR_RST_SERIAL;
         spi_route_select     <= `PPR_RST_SPI;
         timer_a_route_select <= `PPR_RST_TIMER_A;
         timer_b_route_select <= `PPR_RST_TIMER_B;
      end else if (ce && rif.wr_en && rif.wr_lane0) begin
         unique case (rif.wr_idx)
            `PPR_IDX_SERIAL:  serial_route_select  <= rif.wr_data[3:0];
            `PPR_IDX_SPI:     spi_route_select     <= rif.wr_data[1:0];
            `PPR_IDX_TIMER_A: timer_a_route_select <= rif.wr_data[5:0];
            `PPR_IDX_TIMER_B: timer_b_route_select <= rif.wr_data[1:0];
            default: ;
         endcase
      end
   end

   // unused bits read as zero, other indices answer with an error
   always_comb begin
      rif.rd_err = 1'b0;
      unique case (rif.rd_idx)
         `PPR_IDX_SERIAL:  rif.rd_data = {4'h0, serial_route_select};
         `PPR_IDX_SPI:     rif.rd_data = {6'h00, spi_route_select};
         `PPR_IDX_TIMER_A: rif.rd_data = {2'h0, timer_a_route_select};
         `PPR_IDX_TIMER_B: rif.rd_data = {6'h00, timer_b_route_select};
         default: begin
            rif.rd_data = 8'h00;
            rif.rd_err  = 1'b1;
         end
      endcase
   end

   assign rif.wr_err = !(rif.wr_idx inside {`PPR_IDX_SERIAL, `PPR_IDX_SPI,
                                            `PPR_IDX_TIMER_A, `PPR_IDX_TIMER_B});

   // ****************************************************************
   // group view: 0 serial zero, 1 serial one, 2 spi
   // ****************************************************************
   // serial zero, serial one and spi tables
   assign grp_route[0] = ppr_pkg::ppr_route_e'(serial_route_select[`PPR_SER0_LSB +: 2]);
   assign grp_def[0]   = SER0_DEF;
   assign grp_alt[0]   = PA_1TO4;
   assign grp_route[1] = ppr_pkg::ppr_route_e'(serial_route_select[`PPR_SER1_LSB +: 2]);
   assign grp_def[1]   = PA_1TO4;
   assign grp_alt[1]   = PC_ALT;
   assign grp_route[2] = ppr_pkg::ppr_route_e'(spi_route_select[`PPR_SPI_LSB +: 2]);
   assign grp_def[2]   = PA_1TO4;
   assign grp_alt[2]   = PC_ALT;

   assign grp_en  = {spi_port_zero_en, serial_port_one_en, serial_port_zero_en};
   assign grp_out = '{serial_port_zero_out, serial_port_one_out, spi_port_zero_out};
   assign grp_oe  = '{serial_port_zero_oe, serial_port_one_oe, spi_port_zero_oe};

   // ****************************************************************
   // ownership and drive per pin, later writes win
   // ****************************************************************
   always_comb begin
      ppr_pkg::ppr_pin_t p;
      p           = '0;
      own         = '0;
      per_out     = '0;
      per_oe      = '0;
      next_grp_in = '{4'h0, 4'h0, 4'h0};
      for (int i = 0; i < 6; i++) begin
         p = timer_a_route_select[i] ? TMRA_ALT[i] : TMRA_DEF[i];
         if (six_output_timer_en[i]) begin
            own[p]     = 1'b1;
            per_out[p] = six_output_timer_wo[i];
            per_oe[p]  = 1'b1;
         end
      end
      p = timer_b_route_select[`PPR_TMRB0_BIT] ? TMRB0_ALT : TMRB0_DEF;
      if (single_output_timer_zero_en) begin
         own[p]     = 1'b1;
         per_out[p] = single_output_timer_zero_wo;
         per_oe[p]  = 1'b1;
      end
      p = timer_b_route_select[`PPR_TMRB1_BIT] ? TMRB1_ALT : TMRB1_DEF;
      if (single_output_timer_one_en) begin
         own[p]     = 1'b1;
         per_out[p] = single_output_timer_one_wo;
         per_oe[p]  = 1'b1;
      end
      // spi lowest, serial zero highest among groups
      for (int g = 2; g >= 0; g--) begin
         for (int l = 0; l < 4; l++) begin
            p = (grp_route[g] == ppr_pkg::PPR_ROUTE_ALT) ? grp_alt[g][l] : grp_def[g][l];
            // none and reserved leave the group unconnected
            if (grp_route[g] inside {ppr_pkg::PPR_ROUTE_DEFAULT, ppr_pkg::PPR_ROUTE_ALT}) begin
               next_grp_in[g][l] = pin_in[p];
               // enabled peripheral takes over its pins
               if (grp_en[g]) begin
                  own[p]     = 1'b1;
                  per_out[p] = grp_out[g][l];
                  per_oe[p]  = grp_oe[g][l];
               end
            end
         end
      end
   end

   // ****************************************************************
   // registered inputs toward peripherals
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_port_zero_in <= 4'h0;
         serial_port_one_in  <= 4'h0;
         spi_port_zero_in    <= 4'h0;
      end else if (ce) begin
         serial_port_zero_in <= next_grp_in[0];
         serial_port_one_in  <= next_grp_in[1];
         spi_port_zero_in    <= next_grp_in[2];
      end
   end

   // ****************************************************************
   // pin cells
   // ****************************************************************
   // override or general-purpose per pin
   for (genvar n = 0; n < `PPR_PINS; n++) begin : g_pin
      ppr_pin_cell u_cell (
         .aclk     (aclk),
         .aresetn  (aresetn),
         .ce       (ce),
         .gpio_out (gpio_out[n]),
         .gpio_oe  (gpio_oe[n]),
         .own      (own[n]),
         .per_out  (per_out[n]),
         .per_oe   (per_oe[n]),
         .pin_out  (pin_out[n]),
         .pin_oe   (pin_oe[n])
      );
   end

endmodule : ppr_pin_router

// File: tb/ppr_pin_model.sv
// pin level model standing at the router's pads
`timescale 1ns/1ps

module ppr_pin_model (
   input  wire logic        aclk,
   input  wire logic [23:0] pin_out,
   input  wire logic [23:0] pin_oe,
   output logic [23:0]      pin_in
);
   logic [23:0] flt = 24'h000000;

   always @(posedge aclk) flt <= ~flt;
   assign pin_in = (pin_out & pin_oe) | (flt & ~pin_oe);
endmodule : ppr_pin_model

// File: tb/ppr_pin_router_asserts.sv
// concurrent checks on the pin router ports
`timescale 1ns/1ps

module ppr_pin_router_asserts (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [23:0] gpio_oe,
   input wire logic [23:0] pin_oe,
   input wire logic        serial_port_zero_en,
   input wire logic        serial_port_one_en,
   input wire logic        spi_port_zero_en,
   input wire logic [5:0]  six_output_timer_en,
   input wire logic        single_output_timer_zero_en,
   input wire logic        single_output_timer_one_en
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_oe_reset_low: assert property ($rose(aresetn) |-> pin_oe == 24'h000000)
      else $error("pads driven right after reset");
   a_aw_taken_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready stayed up after handshake");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
   a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready)
      else $error("write channel did not recover");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready
      ##1 s_axi_rvalid) else $error("read answer late");
   a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
      else $error("read channel did not recover");
   a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:2] < 6'h02
      || s_axi_araddr[7:2] > 6'h05) |=> ##1 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_gpio_pass: assert property (ce && !serial_port_zero_en && !serial_port_one_en
      && !spi_port_zero_en && six_output_timer_en == 6'h00 && !single_output_timer_zero_en
      && !single_output_timer_one_en |=> pin_oe == $past(gpio_oe))
      else $error("idle pads not under gpio control");
endmodule : ppr_pin_router_asserts

bind ppr_pin_router ppr_pin_router_asserts u_chk (.*);

// File: tb/tb_ppr_pin_router.sv
// self-checking bench of the pin router
`timescale 1ns/1ps

module tb_ppr_pin_router;
   logic            aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic            s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic            s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]      s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]     s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]      s_axi_wstrb = 4'hf;
   logic [1:0]      s_axi_bresp, s_axi_rresp;
   logic [23:0]     gpio_out = 24'h0, gpio_oe = 24'h0, pin_in, pin_out, pin_oe, pin_in_q;
   logic [2:0]      gen = 3'h0;
   logic [2:0][3:0] gout = 12'h0, goe = 12'h0, gin;
   logic [7:0]      ten = 8'h00, two = 8'h00;
   int              failures = 0, checks_done = 0;
   localparam int GP [3][2][4] = '{'{'{10, 11, 9, 8}, '{1, 2, 3, 4}},
      '{'{1, 2, 3, 4}, '{18, 17, 16, 19}}, '{'{1, 2, 3, 4}, '{18, 17, 16, 19}}};
   localparam int TP [8][2] = '{'{8, 11}, '{9, 12}, '{10, 13}, '{3, 19}, '{4, 20}, '{5, 21},
      '{5, 16}, '{3, 20}};
   localparam logic [31:0] MK [2:5] = '{32'hf, 32'h3, 32'h3f, 32'h3};

   ppr_pin_router DUT (.*, .serial_port_zero_en(gen[0]), .serial_port_one_en(gen[1]),
      .spi_port_zero_en(gen[2]), .serial_port_zero_out(gout[0]), .serial_port_one_out(gout[1]),
      .spi_port_zero_out(gout[2]), .serial_port_zero_oe(goe[0]), .serial_port_one_oe(goe[1]),
      .spi_port_zero_oe(goe[2]), .serial_port_zero_in(gin[0]), .serial_port_one_in(gin[1]),
      .spi_port_zero_in(gin[2]), .six_output_timer_en(ten[5:0]), .six_output_timer_wo(two[5:0]),
      .single_output_timer_zero_en(ten[6]), .single_output_timer_zero_wo(two[6]),
      .single_output_timer_one_en(ten[7]), .single_output_timer_one_wo(two[7]));
   ppr_pin_model PM (.*);

   always #5 aclk = ~aclk;
   always @(posedge aclk) pin_in_q <= pin_in;

   task automatic report_and_stop;
      if (failures == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) begin
         failures++;
         report_and_stop();
      end
      chk(32'(s_axi_bresp), 32'(er));
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) begin
         failures++;
         report_and_stop();
      end
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), 32'(er));
      @(posedge aclk);
   endtask : rd

   task automatic grp(input int g, input logic [1:0] r);
      logic [23:0] eo, ee;
      logic [3:0]  ei;
      eo = 24'h0;
      ee = 24'hffffff;
      ei = 4'h0;
      wr(g == 2 ? 8'h0c : 8'h08, 32'(r) << (g == 1 ? 2 : 0), 2'h0);
      gen <= 3'h1 << g;
      gout[g] <= 4'h5;
      goe[g] <= 4'hd;
      repeat (3) @(posedge aclk);
      for (int l = 0; l < 4; l++) begin
         if (r != 2'h3) begin
            ee[GP[g][r][l]] = (l != 1);
            eo[GP[g][r][l]] = !l[0];
            ei[l] = pin_in_q[GP[g][r][l]];
         end
      end
      chk(32'(pin_oe), 32'(ee));
      chk(32'(pin_out), 32'(eo));
      chk(32'(gin[g]), 32'(ei));
   endtask : grp

   task automatic tmr(input int i, input logic r);
      logic [23:0] e;
      e = 24'h0;
      e[TP[i][r]] = 1'b1;
      if (i < 6)
         wr(8'h10, 32'(r) << i, 2'h0);
      else
         wr(8'h14, 32'(r) << (i - 6), 2'h0);
      gen <= 3'h0;
      ten <= 8'h1 << i;
      two <= 8'hff;
      repeat (2) @(posedge aclk);
      chk(32'(pin_out), 32'(e));
      chk(32'(pin_oe), 32'hffffff);
   endtask : tmr

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0, (a > 1 && a < 6) ? 2'h0 : 2'h2);
      s_axi_wstrb <= 4'he;
      wr(8'h08, 32'h5, 2'h0);
      s_axi_wstrb <= 4'hf;
      rd(8'h08, 32'h0, 2'h0);
      wr(8'h1c, 32'h1, 2'h2);
      for (int a = 2; a < 6; a++) begin
         wr(8'(a * 4), 32'hffffffff, 2'h0);
         rd(8'(a * 4), MK[a], 2'h0);
      end
      gpio_oe <= 24'h5a5a5a;
      gpio_out <= 24'h3c3c3c;
      repeat (2) @(posedge aclk);
      chk(32'(pin_oe), 32'h5a5a5a);
      chk(32'(pin_out & pin_oe), 32'h181818);
      ce <= 1'b0;
      gpio_oe <= 24'hffffff;
      gpio_out <= 24'h0;
      repeat (2) @(posedge aclk);
      chk(32'(pin_oe), 32'h5a5a5a);
      ce <= 1'b1;
      for (int g = 0; g < 3; g++) begin
         grp(g, 2'h0);
         grp(g, 2'h1);
         grp(g, 2'h3);
      end
      for (int i = 0; i < 8; i++) begin
         tmr(i, 1'b0);
         tmr(i, 1'b1);
      end
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 2; a < 6; a++) rd(8'(a * 4), 32'h0, 2'h0);
      report_and_stop();
   end
endmodule : tb_ppr_pin_router
